// ==== src/smi_master.sv ====
// Station management master with Avalon-MM register port and interface selection strap.
//
// Contract
// [R1] Management clock never exceeds 2.5 MHz for any divider code.
// [R2] Management clock sits low whenever no transaction runs.
// [R3] Each clock phase lasts at least 160 ns, each period at least 400 ns.
// [R4] Any of 32 PHYs is addressable, one register per transaction.
// [R5] Software writes data first, then addresses, write select set, then busy.
// [R6] Software loads addresses, clears write select, then sets busy.
// [R7] Busy stays high for the whole transaction and clears itself at the end.
// [R8] Address and data register writes are ignored while busy, without error.
// [R9] Software leaves address and data registers alone while busy.
// [R10] Clock derives from bus clock by a 4-bit code; codes 4 to 7 reserved.
// [R11] Code 0 divides by 42, code 1 divides by 64.
// [R12] Code 2 divides by 26, code 3 divides by 16.
// [R13] Software changes the interface select only while the controller rests.
// [R14] After reset the full MII data interface is selected.
// [R15] Frames are preamble, start, opcode, addresses, turnaround, 16 data bits.
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module smi_master
  import smi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic mdc,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic mdio_in,
  output logic rmii_sel
);

  // ==========================================================================
  // Bus slave: one wait state, read data registered
  // ==========================================================================
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  smi_addr_reg_t addr_q;
  smi_addr_reg_t addr_d;
  logic [15:0] data_q;
  logic [15:0] data_d;
  logic rmii_q;
  logic rmii_d;
  logic [31:0] wmask;
  logic wr_acc;

  // The wait state lets read data come from a flop without a combinational decode path.
  always_comb begin
    ack_d = (avs_read | avs_write) & ~ack_q;
    rdata_d = rdata_q;
    if (avs_read && !ack_q) begin
      case (avs_address)
        OFS_ADDR_REG: rdata_d = {16'h0000, addr_q};
        OFS_DATA_REG: rdata_d = {16'h0000, data_q};
        OFS_REMAP_REG: rdata_d = 32'(rmii_q) << RMII_SEL_BIT;
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // Bus flops.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata = rdata_q;
  assign wr_acc = avs_write & ack_q;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
                  {8{avs_byteenable[0]}}};

  // ==========================================================================
  // Management engine and its registers
  // ==========================================================================
  smi_state_t state_q;
  smi_state_t state_d;
  logic [5:0] bit_q;
  logic [5:0] bit_d;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [5:0] half_q;
  logic [5:0] half_d;
  logic [31:0] frame_q;
  logic [31:0] frame_d;
  logic [15:0] rsh_q;
  logic [15:0] rsh_d;
  logic mdc_q;
  logic mdc_d;
  logic mdo_q;
  logic mdo_d;
  logic oe_q;
  logic oe_d;
  logic [15:0] addr_new;
  logic [5:0] nbit;
  logic is_read;

  assign addr_new = (addr_q & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
  assign is_read = ~addr_q.smi_write_select;
  assign nbit = bit_q + 6'h01;

  // Output bit for a frame position: preamble ones, then the latched frame MSB first.
  function automatic logic tx_bit(input logic [5:0] b, input logic [31:0] f);
    logic [5:0] idx;
    idx = LAST_BIT - b;
    tx_bit = (b < PREAMBLE_BITS) ? 1'b1 : f[idx[4:0]];
  endfunction : tx_bit

  // Address and data registers take software writes only while idle; the engine owns them otherwise. The remap register takes writes in any state.
  always_comb begin
    state_d = state_q;
    bit_d = bit_q;
    cnt_d = cnt_q;
    half_d = half_q;
    frame_d = frame_q;
    rsh_d = rsh_q;
    mdc_d = mdc_q;
    mdo_d = mdo_q;
    oe_d = oe_q;
    addr_d = addr_q;
    data_d = data_q;
    rmii_d = rmii_q;
    if (wr_acc && avs_address == OFS_REMAP_REG && avs_byteenable[2]) begin
      rmii_d = avs_writedata[RMII_SEL_BIT];
    end
    case (state_q)
      SMI_IDLE: begin
        mdc_d = 1'b0; // see [R2]
        oe_d = 1'b0;
        if (wr_acc && avs_address == OFS_DATA_REG) begin // see [R8]
          data_d = (data_q & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
        end
        if (wr_acc && avs_address == OFS_ADDR_REG) begin // see [R8]
          addr_d = smi_addr_reg_t'(addr_new);
          if (addr_d.smi_busy_flag) begin
            // Launch: latch the divider and the frame so later writes cannot disturb it.
            half_d = smi_half_cycles(addr_d.clk_sel); // see [R10] see [R11] see [R12] see [R1]
            cnt_d = half_d - 6'h01;
            frame_d = {FRM_START, addr_d.smi_write_select ? FRM_OP_WRITE : FRM_OP_READ,
                       addr_d.phy_addr, addr_d.reg_addr, FRM_TA_WRITE, data_q}; // see [R4] see [R15]
            bit_d = 6'h00;
            mdo_d = 1'b1;
            oe_d = 1'b1;
            state_d = SMI_LOW;
          end
        end
      end
      SMI_LOW: begin
        cnt_d = cnt_q - 6'h01;
        if (cnt_q == 6'h00) begin
          // Rising edge: the PHY drives read data after turnaround, we sample it here.
          mdc_d = 1'b1;
          cnt_d = half_q - 6'h01; // see [R3]
          state_d = SMI_HIGH;
          if (is_read && bit_q >= DATA_FIRST_BIT) begin
            rsh_d = {rsh_q[14:0], mdio_in}; // see [R15]
          end
        end
      end
      SMI_HIGH: begin
        cnt_d = cnt_q - 6'h01;
        if (cnt_q == 6'h00) begin
          mdc_d = 1'b0;
          cnt_d = half_q - 6'h01; // see [R3]
          if (bit_q == LAST_BIT) begin
            // Frame done: drop busy and hand read data to software.
            state_d = SMI_IDLE;
            oe_d = 1'b0;
            addr_d.smi_busy_flag = 1'b0; // see [R7]
            if (is_read) begin
              data_d = rsh_q; // see [R15]
            end
          end else begin
            bit_d = nbit;
            state_d = SMI_LOW;
            mdo_d = tx_bit(nbit, frame_q);
            oe_d = ~(is_read && nbit >= TA_FIRST_BIT); // see [R15]
          end
        end
      end
      default: begin
        state_d = SMI_IDLE;
        mdc_d = 1'b0;
        oe_d = 1'b0;
      end
    endcase
  end

  // Engine flops; the interface strap resets to the full MII interface.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= SMI_IDLE;
      bit_q <= 6'h00;
      cnt_q <= 6'h00;
      half_q <= 6'h00;
      frame_q <= 32'h00000000;
      rsh_q <= 16'h0000;
      mdc_q <= 1'b0;
      mdo_q <= 1'b0;
      oe_q <= 1'b0;
      addr_q <= smi_addr_reg_t'(ADDR_REG_RST);
      data_q <= DATA_REG_RST;
      rmii_q <= RMII_SEL_RST; // see [R14]
    end else begin
      state_q <= state_d;
      bit_q <= bit_d;
      cnt_q <= cnt_d;
      half_q <= half_d;
      frame_q <= frame_d;
      rsh_q <= rsh_d;
      mdc_q <= mdc_d;
      mdo_q <= mdo_d;
      oe_q <= oe_d;
      addr_q <= addr_d;
      data_q <= data_d;
      rmii_q <= rmii_d;
    end
  end

  assign mdc = mdc_q;
  assign mdio_out = mdo_q;
  assign mdio_oe = oe_q;
  assign rmii_sel = rmii_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic [12:0] busy_cnt_q;
  logic [6:0] div_ratio_ref;

  // Full ratio of the latched code, kept apart from the engine's clamped half period.
  // The check then does not lean on the same function that the engine uses.
  always_comb begin
    case (addr_q.clk_sel)
      CSEL_DIV42: div_ratio_ref = DIV_RATIO_42;
      CSEL_DIV64: div_ratio_ref = DIV_RATIO_64;
      CSEL_DIV26: div_ratio_ref = DIV_RATIO_26;
      CSEL_DIV16: div_ratio_ref = DIV_RATIO_16;
      default: div_ratio_ref = DIV_RATIO_64;
    endcase
  end

  // Counts how long busy has been standing, to bound the transaction length.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt_q <= 13'h0000;
    end else begin
      busy_cnt_q <= addr_q.smi_busy_flag ? busy_cnt_q + 13'h0001 : 13'h0000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_high_phase;
    mdc_q[*8];
  endsequence

  sequence s_low_phase;
    !mdc_q[*8];
  endsequence

  sequence s_addr_wr_busy;
    wr_acc && avs_address == OFS_ADDR_REG && addr_q.smi_busy_flag;
  endsequence

  sequence s_launch;
    wr_acc && avs_address == OFS_ADDR_REG && !addr_q.smi_busy_flag && avs_byteenable[0] && avs_writedata[0];
  endsequence

  chk_mdc_idle_low: assert property (!addr_q.smi_busy_flag |-> !mdc_q) // see [R2]
    else $error("management clock high while idle");
  chk_mdc_high_min: assert property ($rose(mdc_q) |-> s_high_phase) // see [R3] see [R1]
    else $error("management clock high phase too short");
  chk_mdc_low_min: assert property ($fell(mdc_q) |-> s_low_phase) // see [R3] see [R1]
    else $error("management clock low phase too short");
  chk_busy_bounded: assert property (busy_cnt_q < BUSY_LIMIT) // see [R7]
    else $error("transaction did not finish in time");
  chk_busy_clear_end: assert property ($fell(addr_q.smi_busy_flag) |-> $past(bit_q) == LAST_BIT && !mdc_q) // see [R7]
    else $error("busy cleared before the last frame bit");
  chk_addr_ignored: assert property (s_addr_wr_busy // see [R8]
    |=> $stable(addr_q.phy_addr) && $stable(addr_q.reg_addr))
    else $error("address register changed while busy");
  chk_data_ignored: assert property (wr_acc && avs_address == OFS_DATA_REG && addr_q.smi_busy_flag
                                     && addr_q.smi_write_select |=> $stable(data_q)) // see [R8]
    else $error("data register changed while busy");
  chk_div_select: assert property ($rose(addr_q.smi_busy_flag) // see [R10] see [R11] see [R12]
    |-> {half_q, 1'b0} == div_ratio_ref)
    else $error("divider does not match the selected code");
  chk_write_drives: assert property (state_q != SMI_IDLE && !is_read |-> oe_q) // see [R15]
    else $error("data line released during a write frame");
  chk_busy_launch: assert property (s_launch |=> addr_q.smi_busy_flag && state_q == SMI_LOW) // see [R7]
    else $error("busy not raised by a launch");
  chk_read_release: assert property (state_q != SMI_IDLE && is_read && bit_q >= TA_FIRST_BIT |-> !oe_q) // see [R15]
    else $error("data line driven during read turnaround or data");
  chk_strap_reset: assert property (@(posedge clk) disable iff (1'b0) $past(rst) |-> !rmii_q) // see [R14]
    else $error("interface select not MII after reset");

endmodule : smi_master

`default_nettype wire

// ==== src/smi_pkg.sv ====
// Package with constants, field layouts and types of the station management master.
`default_nettype none
package smi_pkg;

  // ==========================================================================
  // Clock and management clock timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CLK_FREQ_KHZ = 1000000 / CLK_PERIOD_NS;
  localparam int unsigned MDC_MAX_FREQ_KHZ = 2500;
  localparam int unsigned MDC_MIN_HALF_NS = 160;
  localparam int unsigned MDC_MIN_PERIOD_NS = 400;
  // Least times round up to whole cycles.
  localparam int unsigned MDC_MIN_HALF_CYC = (MDC_MIN_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MDC_MIN_PER_CYC_T = (MDC_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MDC_MIN_PER_CYC_F = (CLK_FREQ_KHZ + MDC_MAX_FREQ_KHZ - 1) / MDC_MAX_FREQ_KHZ;
  localparam int unsigned MDC_MIN_PER_CYC = (MDC_MIN_PER_CYC_T > MDC_MIN_PER_CYC_F) ?
                                            MDC_MIN_PER_CYC_T : MDC_MIN_PER_CYC_F;
  localparam int unsigned MDC_FLOOR_A = (MDC_MIN_PER_CYC + 1) / 2;
  localparam logic [5:0] MDC_HALF_FLOOR = 6'((MDC_FLOOR_A > MDC_MIN_HALF_CYC) ? MDC_FLOOR_A : MDC_MIN_HALF_CYC);

  // ==========================================================================
  // Divider select codes and ratios
  // ==========================================================================
  localparam logic [3:0] CSEL_DIV42 = 4'h0;
  localparam logic [3:0] CSEL_DIV64 = 4'h1;
  localparam logic [3:0] CSEL_DIV26 = 4'h2;
  localparam logic [3:0] CSEL_DIV16 = 4'h3;
  localparam logic [6:0] DIV_RATIO_42 = 7'h2A;
  localparam logic [6:0] DIV_RATIO_64 = 7'h40;
  localparam logic [6:0] DIV_RATIO_26 = 7'h1A;
  localparam logic [6:0] DIV_RATIO_16 = 7'h10;

  // ==========================================================================
  // Register map and reset values
  // ==========================================================================
  localparam logic [3:0] OFS_ADDR_REG = 4'h0;
  localparam logic [3:0] OFS_DATA_REG = 4'h4;
  localparam logic [3:0] OFS_REMAP_REG = 4'h8;
  localparam int unsigned RMII_SEL_BIT = 23;
  localparam logic [15:0] ADDR_REG_RST = 16'h0000;
  localparam logic [15:0] DATA_REG_RST = 16'h0000;
  localparam logic RMII_SEL_RST = 1'b0;

  // ==========================================================================
  // Management frame layout
  // ==========================================================================
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [5:0] LAST_BIT = 6'h3F;
  localparam logic [5:0] TA_FIRST_BIT = 6'h2E;
  localparam logic [5:0] DATA_FIRST_BIT = 6'h30;
  localparam logic [1:0] FRM_START = 2'h1;
  localparam logic [1:0] FRM_OP_READ = 2'h2;
  localparam logic [1:0] FRM_OP_WRITE = 2'h1;
  localparam logic [1:0] FRM_TA_WRITE = 2'h2;
  // Longest time busy may stand, in clock cycles: a frame at the slowest divider plus margin.
  localparam logic [12:0] BUSY_LIMIT = 13'h1080;

  // Address register, busy flag in bit 0 up to the PHY address in bits 15:11.
  typedef struct packed {
    logic [4:0] phy_addr;
    logic [4:0] reg_addr;
    logic [3:0] clk_sel;
    logic smi_write_select;
    logic smi_busy_flag;
  } smi_addr_reg_t;

  typedef enum logic [1:0] {
    SMI_IDLE = 2'b00,
    SMI_LOW = 2'b01,
    SMI_HIGH = 2'b10
  } smi_state_t;

  // Half period in clock cycles for a divider code, never below the floor.
  function automatic logic [5:0] smi_half_cycles(input logic [3:0] code);
    logic [6:0] ratio;
    ratio = DIV_RATIO_64;
    case (code)
      CSEL_DIV42: ratio = DIV_RATIO_42;
      CSEL_DIV64: ratio = DIV_RATIO_64;
      CSEL_DIV26: ratio = DIV_RATIO_26;
      CSEL_DIV16: ratio = DIV_RATIO_16;
      default: ratio = DIV_RATIO_64;
    endcase
    smi_half_cycles = (ratio[6:1] < MDC_HALF_FLOOR) ? MDC_HALF_FLOOR : ratio[6:1];
  endfunction : smi_half_cycles

endpackage : smi_pkg

`default_nettype wire

// ==== tb/smi_phy_model.sv ====
// Behavioural PHY on the far side of the management link.
`timescale 1ns/1ps
`default_nettype none

module smi_phy_model
  import smi_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h11
)
(
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic mdio_in
);
  // ==========================================================================
  // Frame decoder and register store
  // ==========================================================================
  logic [63:0] sr;
  logic [15:0] mem [32];
  logic [1:0] op;
  logic [4:0] pa;
  logic [4:0] ra;
  logic drv;
  logic dout;
  int cnt;

  // The line has a pull-up, so a released line reads high, never the last value.
  assign mdio_in = mdio_oe ? mdio_out : (drv ? dout : 1'b1);

  // Bits are taken on the rising clock edge; a frame is 64 bits.
  always @(posedge mdc or posedge rst) begin
    if (rst) begin
      cnt = 0;
      op = 2'h0;
    end else begin
      sr = {sr[62:0], mdio_in};
      if (cnt == 45) begin
        op = sr[11:10];
        pa = sr[9:5];
        ra = sr[4:0];
      end
      if (cnt == 63 && op == FRM_OP_WRITE && pa == PHY_ADDR) begin
        mem[ra] = sr[15:0];
      end
      cnt = (cnt + 1) % 64;
    end
  end

  // Answer a read only when this PHY is addressed; change data after the falling edge.
  always @(negedge mdc or posedge rst) begin
    if (rst) begin
      drv = 1'b0;
    end else begin
      drv = (op == FRM_OP_READ) && (pa == PHY_ADDR) && (cnt >= 47);
      dout = (cnt == 47) ? 1'b0 : mem[ra][63 - cnt];
    end
  end
endmodule : smi_phy_model

`default_nettype wire

// ==== tb/tb_smi_master.sv ====
// Self-checking testbench of the station management master.
`timescale 1ns/1ps
`default_nettype none

module tb_smi_master
  import smi_pkg::*;
();
  // ==========================================================================
  // Signals, design and far-side model
  // ==========================================================================
  logic clk, rst, avs_read, avs_write, avs_waitrequest, mdc, mdio_out, mdio_oe, mdio_in, rmii_sel, lvl;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  int errors, tests_run, ph, min_ph, hi_max, rises;

  smi_master i_smi_master (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mdc(mdc), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .mdio_in(mdio_in), .rmii_sel(rmii_sel));
  smi_phy_model #(.PHY_ADDR(5'h11)) i_smi_phy_model (.rst(rst), .mdc(mdc), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .mdio_in(mdio_in));

  // Clock of 100 ns.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Phase lengths are counted on the falling edge, where the registered clock output is settled.
  always @(negedge clk) begin
    if (mdc === lvl) begin
      ph++;
    end else begin
      if (ph < min_ph) min_ph = ph;
      if (lvl && ph > hi_max) hi_max = ph;
      if (mdc) rises++;
      lvl = mdc;
      ph = 1;
    end
  end

  // ==========================================================================
  // Compare and bus tasks
  // ==========================================================================
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_n(input string what, input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      errors++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask : chk_n

  // One Avalon access; the request is held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) chk_n("bus answer", 1, 0);
    @(negedge clk);
  endtask : bus

  // Polls the busy flag; the first poll must still see it set.
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, OFS_ADDR_REG, 32'h0000_0000, 4'hF);
      n++;
    end while (q[0] !== 1'b0 && n < 3000);
    chk_n("busy polls above one", 1, int'(n > 1));
  endtask : wait_idle

  // Runs one frame and judges its clock, its field readback and, for a read, its data.
  task automatic frame(input logic [3:0] code, input logic [4:0] pa, input logic [4:0] ra, input logic wr,
                       input logic [15:0] d, input int h);
    logic [31:0] a;
    a = {16'h0000, pa, ra, code, wr, 1'b1};
    if (wr) bus(1'b1, OFS_DATA_REG, {16'h0000, d}, 4'hF);
    min_ph = 9999;
    hi_max = 0;
    rises = 0;
    bus(1'b1, OFS_ADDR_REG, a, 4'hF);
    wait_idle();
    chk("address readback", a & 32'hFFFF_FFFE, q);
    chk_n("clock rises", 64, rises);
    chk_n("shortest phase", h, min_ph);
    chk_n("longest high phase", h, hi_max);
    chk("clock idle", 32'h0000_0000, {31'h0, mdc});
    if (!wr) begin
      bus(1'b0, OFS_DATA_REG, 32'h0000_0000, 4'hF);
      chk("read data", {16'h0000, d}, q);
    end
  endtask : frame

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    chk("clock in reset", 32'h0000_0000, {31'h0, mdc});
    chk("select in reset", 32'h0000_0000, {31'h0, rmii_sel});
    bus(1'b0, OFS_ADDR_REG, 32'h0000_0000, 4'hF);
    chk("address reset", {16'h0000, ADDR_REG_RST}, q);
    bus(1'b0, OFS_DATA_REG, 32'h0000_0000, 4'hF);
    chk("data reset", {16'h0000, DATA_REG_RST}, q);
    bus(1'b0, OFS_REMAP_REG, 32'h0000_0000, 4'hF);
    chk("remap reset", 32'h0000_0000, q);
    bus(1'b0, 4'hC, 32'h0000_0000, 4'hF);
    chk("unmapped read", 32'h0000_0000, q);
    $display("test reset done");
  endtask : t_reset

  task automatic t_remap();
    bus(1'b1, OFS_REMAP_REG, 32'h0080_0000, 4'hB);
    chk("select lane off", 32'h0000_0000, {31'h0, rmii_sel});
    bus(1'b1, OFS_REMAP_REG, 32'h0080_0000, 4'hF);
    chk("select set", 32'h0000_0001, {31'h0, rmii_sel});
    bus(1'b0, OFS_REMAP_REG, 32'h0000_0000, 4'hF);
    chk("remap readback", 32'h0080_0000, q);
    bus(1'b1, OFS_REMAP_REG, 32'h0000_0000, 4'hF);
    chk("select cleared", 32'h0000_0000, {31'h0, rmii_sel});
    // Only the enabled byte lane of the data register may change.
    bus(1'b1, OFS_DATA_REG, 32'h0000_1234, 4'h2);
    bus(1'b0, OFS_DATA_REG, 32'h0000_0000, 4'hF);
    chk("data lane write", 32'h0000_1200, q);
    $display("test remap done");
  endtask : t_remap

  // Every divider code plus one reserved code, then read all back at the fastest code.
  task automatic t_codes();
    int hs[5] = '{21, 32, 13, 8, 32};
    for (int i = 0; i < 5; i++) begin
      frame(4'(i), 5'h11, 5'(i + 1), 1'b1, 16'hA5C0 + 16'(i), hs[i]);
    end
    for (int i = 0; i < 5; i++) begin
      frame(CSEL_DIV16, 5'h11, 5'(i + 1), 1'b0, 16'hA5C0 + 16'(i), 8);
    end
    $display("test codes done");
  endtask : t_codes

  // Writes during a frame are dropped and the frame still completes.
  task automatic t_busy();
    bus(1'b1, OFS_DATA_REG, 32'h0000_BEEF, 4'hF);
    bus(1'b1, OFS_ADDR_REG, {16'h0000, 5'h11, 5'h09, CSEL_DIV16, 1'b1, 1'b1}, 4'hF);
    bus(1'b1, OFS_DATA_REG, 32'h0000_0123, 4'hF);
    bus(1'b1, OFS_ADDR_REG, {16'h0000, 5'h02, 5'h03, CSEL_DIV42, 1'b0, 1'b1}, 4'hF);
    bus(1'b0, OFS_DATA_REG, 32'h0000_0000, 4'hF);
    chk("data while busy", 32'h0000_BEEF, q);
    wait_idle();
    chk("address after dropped write", {16'h0000, 5'h11, 5'h09, CSEL_DIV16, 1'b1, 1'b0}, q);
    frame(CSEL_DIV16, 5'h11, 5'h09, 1'b0, 16'hBEEF, 8);
    frame(CSEL_DIV16, 5'h1F, 5'h09, 1'b0, 16'hFFFF, 8);
    $display("test busy done");
  endtask : t_busy

  task automatic final_report();
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // Main sequence.
  initial begin
    errors = 0;
    tests_run = 0;
    rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    lvl = 1'b0;
    ph = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_remap();
    t_codes();
    t_busy();
    final_report();
  end

  // The tests need about 22000 cycles; 60000 leaves room for slow polling.
  initial begin
    #6000000;
    errors++;
    $display("unexpected watchdog: expected finish, seen hang");
    final_report();
  end
endmodule : tb_smi_master

`default_nettype wire
